// ---- inc/charger_defines.svh ----
// Constants of the charger supervision block
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH
`define MCLK_HZ 64'd40000000
`define TIMEOUT_S 64'd175
`define TIMEOUT_MIN_S 64'd140
`define TIMEOUT_MAX_S 64'd210
`define TMR_W 33
`define DATA_W 16
`define CUR_LIM_0 16'h0400
`define CUR_LIM_1 16'h0800
`define CUR_LIM_2 16'h0c00
`define CUR_LIM_3 16'h1000
`define VOLT_LIM_0 16'h2260
`define VOLT_LIM_1 16'h3330
`define VOLT_LIM_2 16'h4400
`define VOLT_LIM_3 16'h5400
`define VOLT_LIM_4 16'h6d60
`define ST_W 6
`define ST_PFAIL 0
`define ST_ACP 1
`define ST_OVR_I 2
`define ST_OVR_V 3
`define ST_CHG 4
`define ST_TMO 5
`define SETTLE_W 3
`endif

// ---- inc/charger_pkg.sv ----
// Types shared by the charger supervision block
`default_nettype none
package charger_pkg;
  typedef enum logic [1:0] {
    CMD_CUR = 2'h0,
    CMD_VOLT = 2'h1,
    CMD_STAT_READ = 2'h2,
    CMD_ALERT_RESP = 2'h3
  } cmd_kind_t;
  typedef enum logic [1:0] {
    PAIR_NONE = 2'h0,
    PAIR_GOT_CUR = 2'h1,
    PAIR_GOT_VOLT = 2'h2
  } pair_state_t;
endpackage
`default_nettype wire

// ---- inc/cmd_if.sv ----
// Command word carrier from the link crossing to the supervisor
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"
interface cmd_if;
  logic valid;
  charger_pkg::cmd_kind_t kind;
  logic [`DATA_W-1:0] data;
  modport src (output valid, output kind, output data);
  modport dst (input valid, input kind, input data);
endinterface
`default_nettype wire

// ---- logic/level_sync.sv ----
// Two-stage synchroniser for levels
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i, // Destination clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic [W-1:0] d_i, // Foreign level
  output logic [W-1:0] q_o // Synchronised level
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= INIT;
      q_o <= INIT;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- logic/cmd_cross.sv ----
// Toggle handshake carrying link commands into the main clock
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"
module cmd_cross (
  input wire logic link_clk_i, // Link clock
  input wire logic mclk_i, // Main clock
  input wire logic rst_n_i, // Raw async reset
  input wire logic sys_rst_n_i, // Main-domain reset copy
  input wire logic cmd_valid_i, // Link command strobe
  input wire charger_pkg::cmd_kind_t cmd_kind_i, // Command kind
  input wire logic [`DATA_W-1:0] cmd_data_i, // Command word
  output logic busy_o, // Link side busy
  cmd_if.src cmd_o // Main-domain command pulse
);
  logic link_rst_n;
  logic req_tog_reg;
  logic ack_tog_reg;
  logic ack_seen;
  logic req_seen;
  logic accept;
  charger_pkg::cmd_kind_t kind_reg;
  logic [`DATA_W-1:0] data_reg;
  level_sync u_lrst (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(1'b1),
    .q_o(link_rst_n)
  );
  level_sync u_ack (
    .clk_i(link_clk_i),
    .rst_n_i(link_rst_n),
    .d_i(ack_tog_reg),
    .q_o(ack_seen)
  );
  level_sync u_req (
    .clk_i(mclk_i),
    .rst_n_i(sys_rst_n_i),
    .d_i(req_tog_reg),
    .q_o(req_seen)
  );
  assign accept = cmd_valid_i && !busy_o;
  // Word held stable until the main side has acknowledged
  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_tog_reg <= 1'b0;
      busy_o <= 1'b0;
      kind_reg <= charger_pkg::CMD_CUR;
      data_reg <= '0;
    end else if (accept) begin
      req_tog_reg <= ~req_tog_reg;
      busy_o <= 1'b1;
      kind_reg <= cmd_kind_i;
      data_reg <= cmd_data_i;
    end else if (ack_seen == req_tog_reg) begin
      busy_o <= 1'b0;
    end
  end
  always_ff @(posedge mclk_i or negedge sys_rst_n_i) begin
    if (!sys_rst_n_i) begin
      ack_tog_reg <= 1'b0;
      cmd_o.valid <= 1'b0;
      cmd_o.kind <= charger_pkg::CMD_CUR;
      cmd_o.data <= '0;
    end else begin
      ack_tog_reg <= req_seen;
      cmd_o.valid <= req_seen ^ ack_tog_reg;
      cmd_o.kind <= kind_reg;
      cmd_o.data <= data_reg;
    end
  end
endmodule
`default_nettype wire

// ---- logic/charger_ctrl.sv ----
// Charger supervision: set-point pairing, limits, enable line, status and alert
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"
module charger_ctrl #(
  parameter longint unsigned TIMEOUT_CYC = `TIMEOUT_S * `MCLK_HZ,
  parameter int CNT_W = `TMR_W
) (
  input wire logic mclk_i, // Main clock, 40 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic link_clk_i, // Link command clock
  input wire logic cmd_valid_i, // Command strobe, link domain
  input wire charger_pkg::cmd_kind_t cmd_kind_i, // Command kind
  input wire logic [`DATA_W-1:0] cmd_data_i, // Command word
  output logic cmd_busy_o, // Command refused while high
  input wire logic [1:0] current_range_resistor_pin_i, // Current range code
  input wire logic [2:0] voltage_range_pin_i, // Voltage range code
  input wire logic supply_divider_input_i, // Supply comparator
  input wire logic battery_ok_i, // Battery allows charging
  input wire logic charge_enable_line_i, // Enable line level
  output logic charge_enable_line_o, // Enable line drive value
  output logic charge_enable_line_oe_o, // Enable line pulled low
  output logic smbalert_n_o, // Alert drive value
  output logic smbalert_n_oe_o, // Alert pulled low
  output logic adapter_present_output_o, // Adapter present
  output logic [`DATA_W-1:0] current_setpoint_o, // Loaded current code
  output logic [`DATA_W-1:0] voltage_setpoint_o, // Loaded voltage code
  output logic [`ST_W-1:0] status_report_register_o // Status bits
);
  localparam int SYNC_W = 7;
  logic rst_n;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic line_s;
  logic acp_s;
  logic bat_s;
  logic [1:0] irng;
  logic [2:0] vrng;
  cmd_if cmd ();

  // Reset release through two flops
  level_sync u_rst (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  assign raw_in = {charge_enable_line_i, supply_divider_input_i, battery_ok_i,
                   current_range_resistor_pin_i, voltage_range_pin_i[1:0]};
  // Idle line reads high so no false fault at start
  level_sync #(.W(SYNC_W), .INIT(7'h40)) u_in (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .d_i(raw_in),
    .q_o(sync_in)
  );

  logic vrng_hi_s;
  level_sync u_vhi (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .d_i(voltage_range_pin_i[2]),
    .q_o(vrng_hi_s)
  );

  assign line_s = sync_in[6];
  assign acp_s = sync_in[5];
  assign bat_s = sync_in[4];
  assign irng = sync_in[3:2];
  assign vrng = {vrng_hi_s, sync_in[1:0]};

  cmd_cross u_cross (
    .link_clk_i(link_clk_i),
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .sys_rst_n_i(rst_n),
    .cmd_valid_i(cmd_valid_i),
    .cmd_kind_i(cmd_kind_i),
    .cmd_data_i(cmd_data_i),
    .busy_o(cmd_busy_o),
    .cmd_o(cmd.src)
  );

  // Limit decode from the range straps
  logic [`DATA_W-1:0] cur_lim;
  logic [`DATA_W-1:0] volt_lim;
  assign cur_lim = (irng == 2'h0) ? `CUR_LIM_0 :
                   (irng == 2'h1) ? `CUR_LIM_1 :
                   (irng == 2'h2) ? `CUR_LIM_2 : `CUR_LIM_3;
  assign volt_lim = (vrng == 3'h0) ? `VOLT_LIM_0 :
                    (vrng == 3'h1) ? `VOLT_LIM_1 :
                    (vrng == 3'h2) ? `VOLT_LIM_2 :
                    (vrng == 3'h3) ? `VOLT_LIM_3 : `VOLT_LIM_4;

  // Returns {overrange, value used}
  function automatic logic [`DATA_W:0] clamp(input logic [`DATA_W-1:0] code,
                                             input logic [`DATA_W-1:0] lim);
    logic ovr;
    ovr = (code >= lim);
    return {ovr, ovr ? lim : code};
  endfunction

  logic is_cur;
  logic is_volt;
  logic alert_clr;
  logic [`DATA_W:0] cur_cl;
  logic [`DATA_W:0] volt_cl;
  assign is_cur = cmd.valid && (cmd.kind == charger_pkg::CMD_CUR);
  assign is_volt = cmd.valid && (cmd.kind == charger_pkg::CMD_VOLT);
  assign alert_clr = cmd.valid && ((cmd.kind == charger_pkg::CMD_STAT_READ) ||
                                   (cmd.kind == charger_pkg::CMD_ALERT_RESP));
  assign cur_cl = clamp(cmd.data, cur_lim);
  assign volt_cl = clamp(cmd.data, volt_lim);

  // Pending halves of a set-point pair
  logic [`DATA_W-1:0] cur_pend_reg;
  logic [`DATA_W-1:0] cur_pend_next;
  logic [`DATA_W-1:0] volt_pend_reg;
  logic [`DATA_W-1:0] volt_pend_next;
  logic ovr_i_reg;
  logic ovr_v_reg;
  assign cur_pend_next = is_cur ? cur_cl[`DATA_W-1:0] : cur_pend_reg;
  assign volt_pend_next = is_volt ? volt_cl[`DATA_W-1:0] : volt_pend_reg;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_pend_reg <= '0;
      volt_pend_reg <= '0;
      ovr_i_reg <= 1'b0;
      ovr_v_reg <= 1'b0;
    end else begin
      cur_pend_reg <= cur_pend_next;
      volt_pend_reg <= volt_pend_next;
      if (is_cur) begin
        ovr_i_reg <= cur_cl[`DATA_W];
      end
      if (is_volt) begin
        ovr_v_reg <= volt_cl[`DATA_W];
      end
    end
  end

  // Refresh window timer
  logic [CNT_W-1:0] tmr_reg;
  logic expire;
  logic pair_done;
  assign expire = (tmr_reg == CNT_W'(TIMEOUT_CYC - 64'd1));

  charger_pkg::pair_state_t pair_reg;
  charger_pkg::pair_state_t pair_next;
  assign pair_done = ((pair_reg == charger_pkg::PAIR_GOT_CUR) && is_volt) ||
                     ((pair_reg == charger_pkg::PAIR_GOT_VOLT) && is_cur);

  always_comb begin
    pair_next = pair_reg;
    unique case (pair_reg)
      charger_pkg::PAIR_NONE: begin
        if (is_cur) begin
          pair_next = charger_pkg::PAIR_GOT_CUR;
        end else if (is_volt) begin
          pair_next = charger_pkg::PAIR_GOT_VOLT;
        end
      end
      charger_pkg::PAIR_GOT_CUR: begin
        if (is_volt) begin
          pair_next = charger_pkg::PAIR_NONE;
        end
      end
      charger_pkg::PAIR_GOT_VOLT: begin
        if (is_cur) begin
          pair_next = charger_pkg::PAIR_NONE;
        end
      end
      default: pair_next = charger_pkg::PAIR_NONE;
    endcase
    // A lapsed window drops a lone half
    if (expire && !pair_done) begin
      pair_next = charger_pkg::PAIR_NONE;
    end
  end

  logic charge_on_reg;
  logic charge_on_next;
  logic tmo_reg;
  logic chg_ok;
  assign chg_ok = bat_s && acp_s;
  assign charge_on_next = (pair_done && chg_ok) ? 1'b1 :
                          (expire || !chg_ok) ? 1'b0 : charge_on_reg;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pair_reg <= charger_pkg::PAIR_NONE;
      tmr_reg <= '0;
      charge_on_reg <= 1'b0;
      tmo_reg <= 1'b0;
      current_setpoint_o <= '0;
      voltage_setpoint_o <= '0;
    end else begin
      pair_reg <= pair_next;
      tmr_reg <= (pair_done || expire) ? '0 : tmr_reg + 1'b1;
      charge_on_reg <= charge_on_next;
      tmo_reg <= pair_done ? 1'b0 : (expire ? 1'b1 : tmo_reg);
      if (pair_done) begin
        current_setpoint_o <= cur_pend_next;
        voltage_setpoint_o <= volt_pend_next;
      end
    end
  end

  // Enable line: pull low or release, never drive high
  logic [`SETTLE_W-1:0] rel_hist_reg;
  logic ext_low;
  // Own release must settle through the synchroniser first
  assign ext_low = !line_s && (rel_hist_reg == '0) && !charge_enable_line_oe_o;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      charge_enable_line_o <= 1'b0;
      charge_enable_line_oe_o <= 1'b1;
      rel_hist_reg <= '1;
      smbalert_n_o <= 1'b0;
      adapter_present_output_o <= 1'b0;
    end else begin
      charge_enable_line_o <= 1'b0;
      charge_enable_line_oe_o <= !charge_on_next;
      rel_hist_reg <= {rel_hist_reg[`SETTLE_W-2:0], charge_enable_line_oe_o};
      smbalert_n_o <= 1'b0;
      adapter_present_output_o <= acp_s;
    end
  end

  // Status and alert
  logic [`ST_W-1:0] st_next;
  logic st_change;
  always_comb begin
    st_next = '0;
    st_next[`ST_PFAIL] = ext_low || !acp_s;
    st_next[`ST_ACP] = acp_s;
    st_next[`ST_OVR_I] = ovr_i_reg;
    st_next[`ST_OVR_V] = ovr_v_reg;
    st_next[`ST_CHG] = charge_on_reg;
    st_next[`ST_TMO] = tmo_reg;
  end
  assign st_change = (st_next != status_report_register_o);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_report_register_o <= '0;
      smbalert_n_oe_o <= 1'b0;
    end else begin
      status_report_register_o <= st_next;
      // A change in the clearing cycle keeps the alert
      smbalert_n_oe_o <= st_change ? 1'b1 :
                         (alert_clr ? 1'b0 : smbalert_n_oe_o);
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  timer_bound_a: assert property (tmr_reg < CNT_W'(TIMEOUT_CYC))
    else $error("refresh timer passed its window");
  expire_drop_a: assert property (expire && !pair_done |=> !charge_on_reg && charge_enable_line_oe_o)
    else $error("charging kept after window lapsed");
  pair_load_a: assert property (pair_done |=> current_setpoint_o == $past(cur_pend_next)
                                && voltage_setpoint_o == $past(volt_pend_next))
    else $error("set-points not loaded on pair");
  ovr_flag_a: assert property (is_cur |=> ovr_i_reg == ($past(cmd.data) >= $past(cur_lim)))
    else $error("current overrange flag wrong");
  clamp_val_a: assert property (is_volt && cmd.data >= volt_lim |=> volt_pend_reg == $past(volt_lim))
    else $error("limit not substituted");
  line_od_a: assert property (!charge_enable_line_o && (charge_enable_line_oe_o == !charge_on_reg))
    else $error("enable line driven wrongly");
  ext_fault_a: assert property (ext_low |=> status_report_register_o[`ST_PFAIL])
    else $error("external pull-down not flagged");
  acp_fault_a: assert property (!acp_s |=> status_report_register_o[`ST_PFAIL])
    else $error("low supply not flagged");
  alert_set_a: assert property (st_change |=> smbalert_n_oe_o &&
                                status_report_register_o == $past(st_next))
    else $error("status change without alert");
  alert_clr_a: assert property (alert_clr && !st_change |=> !smbalert_n_oe_o)
    else $error("alert not released");
  alert_od_a: assert property (!smbalert_n_o)
    else $error("alert driven high");
  acp_follow_a: assert property (##1 adapter_present_output_o == $past(acp_s))
    else $error("adapter output does not follow comparator");
  range_lim_a: assert property (irng == 2'h0 |-> cur_lim == `CUR_LIM_0)
    else $error("current limit decode wrong");
  tmo_flag_a: assert property (expire && !pair_done |=> tmo_reg)
    else $error("lapsed window not flagged");
  clamp_cur_a: assert property (is_cur && cmd.data >= cur_lim |=> cur_pend_reg == $past(cur_lim))
    else $error("current limit not substituted");
  supply_stop_a: assert property (!acp_s |=> charge_enable_line_oe_o)
    else $error("charging kept without adapter");

  pair_cov_c: cover property (pair_done && chg_ok);
  expire_cov_c: cover property (expire);
  ovr_cov_c: cover property (is_cur && cur_cl[`DATA_W]);
  alert_cov_c: cover property (smbalert_n_oe_o ##1 alert_clr ##1 !smbalert_n_oe_o);
  fault_cov_c: cover property (ext_low);
endmodule
`default_nettype wire

// ---- testbench/smbus_host_model.sv ----
// Link-side host model sending set-point and status commands
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input wire logic cmd_busy_i, // Device refuses while high
  output logic link_clk_o, // Link clock, runs only within a command or an idle call
  output logic cmd_valid_o, // Command strobe
  output charger_pkg::cmd_kind_t cmd_kind_o, // Command kind
  output logic [15:0] cmd_data_o // Command word
);
  // Set at declaration so a task started at time zero is not undone
  logic run = 1'b0;
  initial begin
    link_clk_o = 1'b0;
    cmd_valid_o = 1'b0;
    cmd_kind_o = charger_pkg::CMD_CUR;
    cmd_data_o = 16'h5a5a;
    #7;
    forever #40 link_clk_o = run & ~link_clk_o;
  end
  // Settle just past the edge so the device's own updates have landed
  task automatic tick;
    @(posedge link_clk_o);
    #1;
  endtask
  task automatic idle(input int n);
    run = 1'b1;
    repeat (n) @(posedge link_clk_o);
    run = 1'b0;
  endtask
  // Lead edges delay the command; the strobe is raised once busy reads low and lasts one edge
  task automatic send(input charger_pkg::cmd_kind_t kind, input logic [15:0] data, input int lead);
    int n;
    run = 1'b1;
    repeat (lead) tick();
    n = 0;
    while (cmd_busy_i !== 1'b0 && n < 64) begin
      tick();
      n++;
    end
    cmd_valid_o <= 1'b1;
    cmd_kind_o <= kind;
    cmd_data_o <= data;
    tick();
    cmd_valid_o <= 1'b0;
    cmd_data_o <= ~data;
    n = 0;
    while (cmd_busy_i !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    n = 0;
    while (cmd_busy_i !== 1'b0 && n < 64) begin
      tick();
      n++;
    end
    run = 1'b0;
  endtask
  // Host answers an alert by reading status or by an alert response
  task automatic ack_alert(input logic use_ara);
    send(use_ara ? charger_pkg::CMD_ALERT_RESP : charger_pkg::CMD_STAT_READ, 16'h0000, 2);
  endtask
endmodule
`default_nettype wire

// ---- testbench/charger_ctrl_bench.sv ----
// Self-checking bench for the charger supervision block
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"
module charger_ctrl_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] cur_rng = 2'h0;
  logic [2:0] volt_rng = 3'h0;
  logic supply = 1'b0;
  logic batt_ok = 1'b1;
  logic ext_pull = 1'b0;
  wire line_wire;
  wire alert_wire;
  logic link_clk, cmd_valid, busy, line_drv, line_oe, alert_drv, alert_oe, adapter_present_output;
  charger_pkg::cmd_kind_t cmd_kind;
  logic [15:0] cmd_data, cur_sp, volt_sp;
  logic [5:0] status;
  int mismatches = 0;
  int num_checks = 0;
  logic [15:0] cur_lim [4] = '{`CUR_LIM_0, `CUR_LIM_1, `CUR_LIM_2, `CUR_LIM_3};
  logic [15:0] volt_lim [5] = '{`VOLT_LIM_0, `VOLT_LIM_1, `VOLT_LIM_2, `VOLT_LIM_3, `VOLT_LIM_4};
  always #12.5 mclk = ~mclk;
  // Wired-AND line with pull-up; alert pin open drain with pull-up
  assign line_wire = (line_oe === 1'b1 || ext_pull) ? 1'b0 : 1'b1;
  assign alert_wire = (alert_oe === 1'b1) ? 1'b0 : 1'b1;
  charger_ctrl #(.TIMEOUT_CYC(200)) i_charger_ctrl (
    .mclk_i(mclk), .rst_n_i(rst_n), .link_clk_i(link_clk),
    .cmd_valid_i(cmd_valid), .cmd_kind_i(cmd_kind), .cmd_data_i(cmd_data), .cmd_busy_o(busy),
    .current_range_resistor_pin_i(cur_rng), .voltage_range_pin_i(volt_rng),
    .supply_divider_input_i(supply), .battery_ok_i(batt_ok), .charge_enable_line_i(line_wire),
    .charge_enable_line_o(line_drv), .charge_enable_line_oe_o(line_oe),
    .smbalert_n_o(alert_drv), .smbalert_n_oe_o(alert_oe), .adapter_present_output_o(adapter_present_output),
    .current_setpoint_o(cur_sp), .voltage_setpoint_o(volt_sp), .status_report_register_o(status)
  );
  smbus_host_model i_smbus_host_model (
    .cmd_busy_i(busy), .link_clk_o(link_clk), .cmd_valid_o(cmd_valid),
    .cmd_kind_o(cmd_kind), .cmd_data_o(cmd_data)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pair(input logic [15:0] c, input logic [15:0] v);
    i_smbus_host_model.send(charger_pkg::CMD_CUR, c, 3);
    i_smbus_host_model.send(charger_pkg::CMD_VOLT, v, 3);
    wait_clk(4);
    check(busy, 16'h0, "link free after pair");
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, mismatches);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    int vi;
    fork
      i_smbus_host_model.idle(4);
    join_none
    wait_clk(5);
    check(line_oe, 16'h1, "line pulled in reset");
    check(alert_oe, 16'h0, "alert idle in reset");
    check({cur_sp, volt_sp} == 32'h0, 16'h1, "setpoints cleared");
    check({10'h0, status}, 16'h0, "status cleared");
    @(posedge mclk);
    rst_n <= 1'b1;
    supply <= 1'b1;
    end_test("reset");
    wait_clk(10);
    check(adapter_present_output, 16'h1, "adapter present");
    check(status[1:0], 16'h2, "adapter bit, no power fail");
    check(alert_wire, 16'h0, "alert on status change");
    i_smbus_host_model.ack_alert(1'b0);
    wait_clk(2);
    check(alert_wire, 16'h1, "alert released by status read");
    end_test("adapter");
    for (int i = 0; i < 6; i++) begin
      vi = (i == 5) ? 4 : i;
      @(posedge mclk);
      cur_rng <= 2'(i % 4);
      volt_rng <= (i == 5) ? 3'h7 : 3'(i);
      wait_clk(4);
      pair((i % 2) ? 16'hffff : cur_lim[i % 4], (i % 2) ? 16'hffff : volt_lim[vi]);
      check(cur_sp, cur_lim[i % 4], "current limited by range");
      check(volt_sp, volt_lim[vi], "voltage limited by range");
      check(status[3:2], 16'h3, "overrange flags");
    end
    i_smbus_host_model.ack_alert(1'b0);
    wait_clk(2);
    check(alert_wire, 16'h1, "alert released");
    end_test("overrange");
    @(posedge mclk);
    cur_rng <= 2'h0;
    volt_rng <= 3'h0;
    wait_clk(4);
    pair(16'h03ff, 16'h225f);
    check(cur_sp, 16'h03ff, "current loaded");
    check(volt_sp, 16'h225f, "voltage loaded");
    check({10'h0, status}, 16'h0012, "status after in-range pair");
    check(line_wire, 16'h1, "line released while charging");
    check({line_drv, alert_drv}, 16'h0, "pins only pull low");
    check(alert_wire, 16'h0, "alert on new status");
    i_smbus_host_model.ack_alert(1'b1);
    wait_clk(2);
    check(alert_wire, 16'h1, "alert released by response");
    end_test("pair");
    @(posedge mclk);
    ext_pull <= 1'b1;
    wait_clk(1);
    check(status[0], 16'h0, "short pull not yet seen");
    wait_clk(8);
    check(line_wire, 16'h0, "line forced low");
    check(status[0], 16'h1, "power fail on external pull");
    @(posedge mclk);
    ext_pull <= 1'b0;
    wait_clk(8);
    check(status[0], 16'h0, "power fail gone");
    end_test("pull");
    pair(16'h0100, 16'h1000);
    check(status[5], 16'h0, "window open");
    i_smbus_host_model.send(charger_pkg::CMD_CUR, 16'h0200, 3);
    wait_clk(100);
    check({status[5], line_oe}, 16'h0, "lone half keeps window");
    wait_clk(100);
    check({status[5], line_oe}, 16'h3, "window lapsed, charging off");
    pair(16'h0100, 16'h1000);
    check({status[5], line_oe}, 16'h0, "refresh restarts charging");
    end_test("window");
    @(posedge mclk);
    supply <= 1'b0;
    wait_clk(6);
    check(adapter_present_output, 16'h0, "adapter gone");
    check(status[1:0], 16'h1, "power fail without adapter");
    check(line_oe, 16'h1, "charging off without adapter");
    @(posedge mclk);
    supply <= 1'b1;
    batt_ok <= 1'b0;
    wait_clk(6);
    pair(16'h0300, 16'h2000);
    check(volt_sp, 16'h2000, "loaded with battery inhibit");
    check(line_oe, 16'h1, "battery inhibits charging");
    end_test("supply");
    final_report();
  end
endmodule
`default_nettype wire
